// File: hw/spc_defs.vh
// Constants of the pressure sensor link controller: offsets, fields, reset values, timing
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// Register byte offsets on the AHB-Lite side
`define SPC_OFS_CTRL     8'h00
`define SPC_OFS_MADDR    8'h04
`define SPC_OFS_WDATA    8'h08
`define SPC_OFS_STATUS   8'h0c
`define SPC_OFS_RDATA    8'h10
`define SPC_OFS_RDATA_LAST 8'h1c

// Control register fields
`define SPC_CTRL_GO      0
`define SPC_CTRL_PROT    1
`define SPC_CTRL_OP_LO   2
`define SPC_CTRL_OP_HI   3
`define SPC_CTRL_SLV_LO  8
`define SPC_CTRL_SLV_HI  14
`define SPC_CTRL_CNT_LO  16
`define SPC_CTRL_CNT_HI  20

// Status register fields
`define SPC_ST_BUSY      0
`define SPC_ST_DONE      1
`define SPC_ST_NACK      2
`define SPC_ST_CRC       3

// Operation codes
`define SPC_OP_WRITE     2'h0
`define SPC_OP_READ      2'h1
`define SPC_OP_LAST      2'h2
`define SPC_OP_WAKE      2'h3

// Reset values
`define SPC_SLAVE_RST    7'h00
`define SPC_CNT_RST      5'h02

// Length limits in bytes
`define SPC_MAX_PROT_RD  5'h10
`define SPC_MAX_WR       5'h04

// Frame check generators and start values
`define SPC_HEADER_CHECK_NIBBLE_POLY    4'h3
`define SPC_HEADER_CHECK_NIBBLE_INIT    4'hf
`define SPC_FRAME_CHECK_BYTE_POLY    8'hd5
`define SPC_FRAME_CHECK_BYTE_INIT    8'hff

// Timing: a quarter of the serial clock period, and the system clock period
`define SPC_QUARTER_NS   2500
`define SPC_HCLK_NS      100
`define SPC_QUARTER_CYC  (`SPC_QUARTER_NS / `SPC_HCLK_NS)

`endif

// File: hw/spc_crc.v
// Bit-serial frame check register, MSB-first, used for both check widths
`default_nettype none
`include "spc_defs.vh"

module spc_crc #(
  parameter integer           WIDTH = 8,
  parameter [WIDTH-1:0]       POLY  = `SPC_FRAME_CHECK_BYTE_POLY,
  parameter [WIDTH-1:0]       INIT  = `SPC_FRAME_CHECK_BYTE_INIT
) (
  // Clock and reset
  input  wire                 hclk,
  input  wire                 hresetn,
  // Control
  input  wire                 init,     // Hold at start value
  input  wire                 shift,    // Take one bus bit
  input  wire                 din,      // Bit as it travels on the bus
  // Result
  output reg  [WIDTH-1:0]     crc
);

  // Feedback term: top bit against incoming bit
  wire fb;
  assign fb = crc[WIDTH-1] ^ din;

  // Shift register; init has priority so a new frame always restarts cleanly
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= INIT;
    end else if (init) begin
      crc <= INIT;
    end else if (shift) begin
      crc <= {crc[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
    end
  end

endmodule
`default_nettype wire

// File: hw/spc_i2c_host.v
// Host controller driving the pressure sensor's serial link, with an AHB-Lite register slave
//
// Operation
// - Random write sets pointer, stores successive bytes
// - Random read sets pointer, returns successive bytes
// - Host uses even address, even byte count
// - Address LSB selects plain or protected frame
// - Address byte holds first byte address
// - Low byte first, bits MSB first
// - Length nibble holds byte count minus one
// - Protected: read 16, write 4 bytes max
// - Header check: poly 0x03, start 0x0F
// - Frame check: poly 0xD5, start 0xFF
// - Checks follow exact bus bit order
// - Rising serial clock wakes sleeping device
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`default_nettype none
`include "spc_defs.vh"

module spc_i2c_host #(
  parameter integer QUARTER = `SPC_QUARTER_CYC  // Cycles per quarter serial clock
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Serial clock pin, open drain
  input  wire        scl_i,
  output wire        scl_o,
  output reg         scl_oe,
  // Serial data pin, open drain
  input  wire        sda_i,
  output wire        sda_o,
  output reg         sda_oe
);

  // Sequencer states
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_START  = 4'h1;
  localparam [3:0] S_SLAW   = 4'h2;
  localparam [3:0] S_MADDR  = 4'h3;
  localparam [3:0] S_LEN    = 4'h4;
  localparam [3:0] S_WDATA  = 4'h5;
  localparam [3:0] S_WCRC   = 4'h6;
  localparam [3:0] S_RSTART = 4'h7;
  localparam [3:0] S_SLAR   = 4'h8;
  localparam [3:0] S_RDATA  = 4'h9;
  localparam [3:0] S_RCRC   = 4'ha;
  localparam [3:0] S_STOP   = 4'hb;
  localparam [3:0] S_WAKE   = 4'hc;

  integer i;

  // Software registers
  reg  [6:0]  ctrl_slave;        // Even base slave address
  reg         ctrl_prot;         // Use protected frames
  reg  [1:0]  ctrl_op;           // Operation code
  reg  [4:0]  ctrl_cnt;          // Byte count requested
  reg  [7:0]  ctrl_maddr;        // Memory byte address
  reg  [31:0] ctrl_wdata;        // Write bytes, byte 0 sent first
  reg         st_done;           // Sticky: operation finished
  reg         st_nack;           // Sticky: device refused a byte
  reg         st_crc;            // Sticky: read frame check mismatch
  reg  [7:0]  rbuf [0:15];       // Received bytes in bus order

  // Bus slave pipeline
  reg         dp_wr;             // Write data phase pending
  reg         dp_rd;             // Read data phase pending
  reg         rd_ready;          // Read data loaded
  reg  [7:0]  dp_addr;           // Data phase byte offset

  // Latched operation
  reg  [6:0]  act_slave;
  reg         act_prot;
  reg  [1:0]  act_op;
  reg  [4:0]  act_cnt;
  reg  [7:0]  act_maddr;
  reg  [31:0] act_wdata;

  // Link engine
  reg  [3:0]  seq;               // Sequencer state
  reg  [1:0]  q;                 // Quarter of current bit
  reg  [7:0]  qcnt;              // Cycles within quarter
  reg  [3:0]  bitcnt;            // 0..7 data, 8 acknowledge
  reg  [4:0]  byte_idx;          // Data byte index
  reg  [7:0]  rx;                // Received shift register
  reg         nack_seen;         // Acknowledge bit was high
  reg  [2:0]  sda_sync;          // Pin sampler chain
  reg  [2:0]  scl_sync;
  reg         sda_in;            // Filtered pin levels
  reg         scl_in;
  reg         next_scl;          // Wanted pin levels
  reg         next_sda;

  wire [3:0]  header_check_nibble;
  wire [7:0]  frame_check_byte;

  // Bus side decode
  wire        take    = hsel & htrans[1] & hready;
  wire        busy    = (seq != S_IDLE);
  wire        wr_ctrl = dp_wr & (dp_addr == `SPC_OFS_CTRL);
  wire        go      = wr_ctrl & hwdata[`SPC_CTRL_GO] & ~busy;
  wire        wr_st   = dp_wr & (dp_addr == `SPC_OFS_STATUS);

  // Single-word AHB-Lite slave: writes take no wait, reads one wait state
  assign hreadyout = ~(dp_rd & ~rd_ready);
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;

  // Even count of at least two, clamped to buffer and frame limits
  wire [4:0]  cnt_even = (ctrl_cnt[4:1] == 4'h0) ? 5'h02 : {ctrl_cnt[4:1], 1'b0};
  wire        op_wr    = (ctrl_op == `SPC_OP_WRITE);
  wire [4:0]  cnt_lim  = op_wr ? `SPC_MAX_WR : `SPC_MAX_PROT_RD;
  wire [4:0]  cnt_use  = (cnt_even > cnt_lim) ? cnt_lim : cnt_even;

  // Step decode
  wire        tick     = (qcnt == QUARTER[7:0] - 8'h01) & ~((q == 2'h1) & ~scl_in);
  wire        is_start = (seq == S_START) | (seq == S_RSTART);
  wire        is_stop  = (seq == S_STOP) | (seq == S_WAKE);
  wire        is_rd    = (seq == S_RDATA) | (seq == S_RCRC);
  wire        is_byte  = busy & ~is_start & ~is_stop;
  wire        last     = (byte_idx == act_cnt - 5'h01);
  wire        step_end = tick & (q == 2'h3) & (~is_byte | (bitcnt == 4'h8));
  wire        sample   = tick & (q == 2'h2);
  wire [3:0]  len_m1   = act_cnt[3:0] - 4'h1;

  // Byte offered by the host in each state
  reg  [7:0]  tx_byte;
  always @* begin
    case (seq)
      S_SLAW:  tx_byte = {act_slave[6:1], act_prot, 1'b0};
      S_SLAR:  tx_byte = {act_slave[6:1], act_prot, 1'b1};
      S_MADDR: tx_byte = {act_maddr[7:1], 1'b0};
      S_LEN:   tx_byte = {len_m1, header_check_nibble};
      S_WDATA: tx_byte = act_wdata[{byte_idx[1:0], 3'h0} +: 8];
      S_WCRC:  tx_byte = frame_check_byte;
      default: tx_byte = 8'hff;
    endcase
  end

  // Bit driven during a byte: data MSB first, then acknowledge slot
  wire        tx_bit  = tx_byte[3'h7 - bitcnt[2:0]];
  wire        ack_bit = (seq == S_RCRC) | (last & ~act_prot);
  wire        bus_bit = is_rd ? sda_in : tx_bit;
  wire        header_check_nibble_sh = sample & (bitcnt < 4'h8) &
                        ((seq == S_SLAW) | (seq == S_MADDR) | ((seq == S_LEN) & (bitcnt < 4'h4)));
  wire        frame_check_byte_sh = sample & is_byte & (bitcnt < 4'h8) &
                        (seq != S_WCRC) & (seq != S_RCRC);

  // Header check nibble over address bytes and length nibble
  spc_crc #(.WIDTH(4), .POLY(`SPC_HEADER_CHECK_NIBBLE_POLY), .INIT(`SPC_HEADER_CHECK_NIBBLE_INIT)) u_header_check_nibble (
    .hclk    (hclk),
    .hresetn (hresetn),
    .init    (~busy),
    .shift   (header_check_nibble_sh),
    .din     (tx_bit),
    .crc     (header_check_nibble)
  );

  // Frame check byte over every bus byte before it
  spc_crc #(.WIDTH(8), .POLY(`SPC_FRAME_CHECK_BYTE_POLY), .INIT(`SPC_FRAME_CHECK_BYTE_INIT)) u_frame_check_byte (
    .hclk    (hclk),
    .hresetn (hresetn),
    .init    (~busy),
    .shift   (frame_check_byte_sh),
    .din     (bus_bit),
    .crc     (frame_check_byte)
  );

  // Wanted pin levels per step and quarter
  always @* begin
    next_scl = 1'b1;
    next_sda = 1'b1;
    if (is_start) begin
      next_scl = (q == 2'h0) ? (seq == S_START) : (q != 2'h3);
      next_sda = (q == 2'h0) | (q == 2'h1);
    end else if (is_stop) begin
      next_scl = (q != 2'h0);
      next_sda = (q == 2'h2) | (q == 2'h3);
    end else if (is_byte) begin
      next_scl = (q == 2'h1) | (q == 2'h2);
      if (bitcnt == 4'h8) begin
        next_sda = is_rd ? ack_bit : 1'b1;
      end else begin
        next_sda = is_rd ? 1'b1 : tx_bit;
      end
    end
  end

  // Pin drivers from flops; enable high pulls the line low
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= ~next_scl;
      sda_oe <= ~next_sda;
    end
  end

  // Pin samplers: a level counts once the second and third stage agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_sync <= 3'h7;
      scl_sync <= 3'h7;
      sda_in   <= 1'b1;
      scl_in   <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], sda_i};
      scl_sync <= {scl_sync[1:0], scl_i};
      if (sda_sync[1] == sda_sync[2]) begin
        sda_in <= sda_sync[2];
      end
      if (scl_sync[1] == scl_sync[2]) begin
        scl_in <= scl_sync[2];
      end
    end
  end

  // Sequencer: quarters, bits, bytes and frame steps
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq       <= S_IDLE;
      q         <= 2'h0;
      qcnt      <= 8'h00;
      bitcnt    <= 4'h0;
      byte_idx  <= 5'h00;
      rx        <= 8'h00;
      nack_seen <= 1'b0;
      act_slave <= `SPC_SLAVE_RST;
      act_prot  <= 1'b0;
      act_op    <= `SPC_OP_WRITE;
      act_cnt   <= `SPC_CNT_RST;
      act_maddr <= 8'h00;
      act_wdata <= 32'h0000_0000;
      for (i = 0; i < 16; i = i + 1) begin
        rbuf[i] <= 8'h00;
      end
    end else if (!busy) begin
      // Idle: wait for a start order, freezing its parameters
      q         <= 2'h0;
      qcnt      <= 8'h00;
      bitcnt    <= 4'h0;
      byte_idx  <= 5'h00;
      nack_seen <= 1'b0;
      if (go) begin
        act_slave <= hwdata[`SPC_CTRL_SLV_HI:`SPC_CTRL_SLV_LO];
        act_prot  <= ctrl_prot;
        act_op    <= ctrl_op;
        act_cnt   <= cnt_use;
        act_maddr <= ctrl_maddr;
        act_wdata <= ctrl_wdata;
        seq       <= (ctrl_op == `SPC_OP_WAKE) ? S_WAKE : S_START;
      end
    end else begin
      // Quarter timer; a held-low serial clock stretches the high quarter
      if (tick) begin
        qcnt <= 8'h00;
        q    <= q + 2'h1;
      end else if (!((q == 2'h1) & ~scl_in)) begin
        qcnt <= qcnt + 8'h01;
      end
      // Sample point at the end of the high window
      if (sample & is_byte) begin
        if (bitcnt < 4'h8) begin
          rx <= {rx[6:0], sda_in};
        end else if (!is_rd) begin
          nack_seen <= sda_in;
        end
      end
      if (tick & (q == 2'h3) & is_byte & (bitcnt != 4'h8)) begin
        bitcnt <= bitcnt + 4'h1;
      end
      // Step transitions
      if (step_end) begin
        bitcnt <= 4'h0;
        case (seq)
          S_START:  seq <= (act_op == `SPC_OP_LAST) ? S_SLAR : S_SLAW;
          S_SLAW:   seq <= nack_seen ? S_STOP : S_MADDR;
          S_MADDR: begin
            if (nack_seen) begin
              seq <= S_STOP;
            end else if (act_prot) begin
              seq <= S_LEN;
            end else begin
              seq <= (act_op == `SPC_OP_WRITE) ? S_WDATA : S_RSTART;
            end
          end
          S_LEN: begin
            if (nack_seen) begin
              seq <= S_STOP;
            end else begin
              seq <= (act_op == `SPC_OP_WRITE) ? S_WDATA : S_RSTART;
            end
          end
          S_WDATA: begin
            byte_idx <= byte_idx + 5'h01;
            if (nack_seen) begin
              seq <= S_STOP;
            end else if (last) begin
              seq <= act_prot ? S_WCRC : S_STOP;
            end
          end
          S_WCRC:   seq <= S_STOP;
          S_RSTART: seq <= S_SLAR;
          S_SLAR:   seq <= nack_seen ? S_STOP : S_RDATA;
          S_RDATA: begin
            rbuf[byte_idx[3:0]] <= rx;
            byte_idx <= byte_idx + 5'h01;
            if (last) begin
              seq <= act_prot ? S_RCRC : S_STOP;
            end
          end
          S_RCRC:   seq <= S_STOP;
          default:  seq <= S_IDLE;
        endcase
      end
    end
  end

  // Event conditions at the end of a frame step
  wire ev_nack = step_end & is_byte & ~is_rd & nack_seen;
  wire ev_crc  = step_end & (seq == S_RCRC) & (rx != frame_check_byte);
  wire ev_done = step_end & is_stop;

  // Software registers; a hardware set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_slave <= `SPC_SLAVE_RST;
      ctrl_prot  <= 1'b0;
      ctrl_op    <= `SPC_OP_WRITE;
      ctrl_cnt   <= `SPC_CNT_RST;
      ctrl_maddr <= 8'h00;
      ctrl_wdata <= 32'h0000_0000;
      st_done    <= 1'b0;
      st_nack    <= 1'b0;
      st_crc     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_slave <= hwdata[`SPC_CTRL_SLV_HI:`SPC_CTRL_SLV_LO];
        ctrl_prot  <= hwdata[`SPC_CTRL_PROT];
        ctrl_op    <= hwdata[`SPC_CTRL_OP_HI:`SPC_CTRL_OP_LO];
        ctrl_cnt   <= hwdata[`SPC_CTRL_CNT_HI:`SPC_CTRL_CNT_LO];
      end
      if (dp_wr & (dp_addr == `SPC_OFS_MADDR)) begin
        ctrl_maddr <= {hwdata[7:1], 1'b0};
      end
      if (dp_wr & (dp_addr == `SPC_OFS_WDATA)) begin
        ctrl_wdata <= hwdata;
      end
      st_done <= ev_done | (st_done & ~(wr_st & hwdata[`SPC_ST_DONE]));
      st_nack <= ev_nack | (st_nack & ~(wr_st & hwdata[`SPC_ST_NACK]));
      st_crc  <= ev_crc  | (st_crc  & ~(wr_st & hwdata[`SPC_ST_CRC]));
    end
  end

  // Bus pipeline and read data; read value is formed in the wait cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr    <= 1'b0;
      dp_rd    <= 1'b0;
      rd_ready <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      if (hready) begin
        dp_wr    <= take & hwrite;
        dp_rd    <= take & ~hwrite;
        rd_ready <= 1'b0;
        if (take) begin
          dp_addr <= {haddr[7:2], 2'h0};
        end
      end else if (dp_rd) begin
        rd_ready <= 1'b1;
        if (dp_addr == `SPC_OFS_CTRL) begin
          hrdata <= {11'h000, ctrl_cnt, 1'b0, ctrl_slave, 4'h0, ctrl_op, ctrl_prot, 1'b0};
        end else if (dp_addr == `SPC_OFS_MADDR) begin
          hrdata <= {24'h000000, ctrl_maddr};
        end else if (dp_addr == `SPC_OFS_WDATA) begin
          hrdata <= ctrl_wdata;
        end else if (dp_addr == `SPC_OFS_STATUS) begin
          hrdata <= {28'h0000000, st_crc, st_nack, st_done, busy};
        end else if ((dp_addr >= `SPC_OFS_RDATA) & (dp_addr <= `SPC_OFS_RDATA_LAST)) begin
          // Byte 4k lands in bits 7:0, so word data reads low byte first
          hrdata <= {rbuf[{dp_addr[3:2], 2'h3}], rbuf[{dp_addr[3:2], 2'h2}],
                     rbuf[{dp_addr[3:2], 2'h1}], rbuf[{dp_addr[3:2], 2'h0}]};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/spc_chk_asserts.sv
// Checker for the link controller's bus and pin behaviour
`default_nettype none
module spc_chk #(
  parameter integer QUARTER = 4
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // AHB-Lite side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Serial pins
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic   taken = hsel && htrans[1] && hready; // Accepted address phase
  logic [15:0] hold;                                // Cycles SCL enable has stood
  // Phase length; starts saturated so the idle line never trips it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hold <= 16'hffff;
    else if ($changed(scl_oe)) hold <= 16'h1;
    else if (hold != 16'hffff) hold <= hold + 16'h1;
  end
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  AST_WR_NOWAIT: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase waited");
  AST_RD_ONE_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_UNMAPPED: assert property (taken && !hwrite && haddr[7:5] != 3'h0 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RESET_IDLE: assert property ($rose(hresetn) |-> !scl_oe && !sda_oe)
    else $error("lines not released after reset");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  AST_SCL_PHASE: assert property ($changed(scl_oe) |-> hold >= QUARTER)
    else $error("scl phase too short");
  AST_GO_STARTS: assert property (taken && hwrite && haddr[7:0] == 8'h0 ##1 hwdata[0]
    |-> ##[1:400] sda_oe)
    else $error("go without bus activity");
endmodule
`default_nettype wire

// File: verif/spc_dev_model.sv
// Behavioural model of the sensor's serial register port
`default_nettype none
module spc_dev_model (
  // Board wires
  input  wire logic       scl,
  input  wire logic       sda,
  output var  logic       sda_pull,
  // Fault injection
  input  wire logic [1:0] fault,
  input  wire logic       bad_crc
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] BASE = 7'h2a; // Arbitrary even address
  logic [7:0] mem [0:63];  // Register space
  logic [7:0] wb [0:3];    // Protected write data, held until checked
  logic [7:0] sr, tx, ptr, lptr, stat, lo, c8;
  logic [3:0] c4;
  int         bc, nb, len;
  logic       rd, pr, act, mack, sleep, nap, dozy, bad;
  function automatic logic [7:0] f8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'hd5 : 8'h0);
    return c;
  endfunction
  function automatic logic [3:0] f4(input logic [3:0] c, input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ b[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction
  // Power-up load, also run by the reset command; clears status and sleep
  task automatic init;
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 29 + 7);
    stat = 8'h0;
    sleep = 0;
    nap = 0;
  endtask
  // Word actions fire on the high byte; all else is protected
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    if (!a[0]) lo = b;
    else if (a == 8'h37) stat = stat & ~lo;
    else if (a == 8'h23 && {b, lo} == 16'h6c32) nap = 1;
    else if (a == 8'h23 && {b, lo} == 16'hb169) init;
  endtask
  // Byte received from the master
  task automatic rx;
    if (nb != 0 && !act) return;
    if (nb == 0) begin
      act = !sleep && !dozy && sr[7:2] == BASE[6:1];
      pr = sr[1];
      rd = sr[0];
      if (rd) ptr = lptr;
      else c4 = f4(4'hf, sr, 8);
      c8 = f8(c8, sr);
    end else if (nb == 1) begin
      lptr = sr;
      ptr = sr;
      c4 = f4(c4, sr, 8);
      c8 = f8(c8, sr);
    end else if (pr && nb == 2) begin
      len = sr[7:4] + 1;
      bad = f4(c4, sr, 4) != sr[3:0];
      if (bad) stat[2] = 1;
      c8 = f8(c8, sr);
    end else if (!pr) begin
      put(ptr, sr);
      ptr = ptr + 1;
    end else if (nb - 3 < len) begin
      wb[(nb - 3) % 4] = sr;
      c8 = f8(c8, sr);
    end else if (nb - 3 == len) begin
      if (bad || sr != c8) stat[2] = 1;
      else for (int i = 0; i < len; i++) put(ptr + 8'(i), wb[i]);
    end
    sda_pull = act;
  endtask
  // Next byte to the master; check byte after the data when protected
  task automatic send;
    if (pr && nb > len) tx = c8 ^ {7'h0, bad_crc};
    else begin
      tx = (ptr == 8'h36) ? stat : (ptr == 8'h37) ? 8'h0 : mem[ptr[5:0]];
      ptr = ptr + 1;
      c8 = f8(c8, tx);
    end
    sda_pull = !tx[7];
  endtask
  initial begin
    init;
    c8 = 8'hff;
    act = 0;
    dozy = 0;
    sda_pull = 0;
  end
  always @(fault) stat = stat | {6'h0, fault};
  // Start and stop conditions
  always @(negedge sda) if (scl) begin
    bc = 0;
    nb = 0;
  end
  always @(posedge sda) if (scl) begin
    act = 0;
    c8 = 8'hff;
    dozy = 0;
    sleep = nap;
    nap = 0;
  end
  // Sampling edge; a sleeping part wakes and sits out the frame
  always @(posedge scl) begin
    if (sleep) begin
      sleep = 0;
      dozy = 1;
    end
    bc = bc + 1;
    if (bc < 9) sr = {sr[6:0], sda};
    else mack = !sda;
  end
  // Driving edge
  always @(negedge scl) begin
    if (bc == 8 && (nb == 0 || !rd)) rx;
    else if (bc == 8) sda_pull = 0;
    else if (bc == 9) begin
      bc = 0;
      nb = nb + 1;
      sda_pull = 0;
      if (rd && act && (nb == 1 || mack)) send;
      else if (rd) act = 0;
    end else if (rd && act && bc > 0 && bc < 8) sda_pull = !tx[7 - bc];
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench: link controller against the sensor model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLV = 7'h2a; // Model address, arbitrary
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bad_crc = 0, p;
  logic [31:0] haddr = 0, hwdata = 0, rd, st, wd;
  logic [1:0]  htrans = 0, fault = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  a;
  logic [4:0]  n;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, scl_o, sda_o, scl_oe, sda_oe, pull;
  wire         scl = !scl_oe;          // Pull-ups on both lines
  wire         sda = !sda_oe && !pull;
  int          num_errors = 0, n_tests = 0;
  always #50 hclk = ~hclk;
  spc_i2c_host #(.QUARTER(4)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  spc_dev_model u_dev (.scl(scl), .sda(sda), .sda_pull(pull), .fault(fault), .bad_crc(bad_crc));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One AHB single transfer; address held until hready, data until hready
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // One link operation; returns status at completion, then clears it
  task automatic xfer(input logic [1:0] op, input logic pp, input logic [6:0] s,
                      input logic [7:0] ma, input logic [4:0] cn, input logic [31:0] d,
                      output logic [31:0] q);
    logic [31:0] c;
    c = {11'h0, cn, 1'b0, s, 4'h0, op, pp, 1'b0};
    bus(1, 8'h04, {24'h0, ma}, q);
    bus(1, 8'h08, d, q);
    bus(1, 8'h00, c, q);
    bus(1, 8'h00, c | 32'h1, q);
    do bus(0, 8'h0c, 32'h0, q); while (q[1] !== 1'b1);
    bus(1, 8'h0c, 32'he, c);
  endtask
  function automatic logic [7:0] eb(input logic [7:0] ad);
    return ad * 8'h1d + 8'h07;
  endfunction
  task automatic rdchk(input logic [7:0] ad, input logic [4:0] cn);
    for (int j = 0; j < cn; j++) begin
      bus(0, 8'h10 + 8'(j / 4 * 4), 32'h0, rd);
      chk("rdata byte", {24'h0, eb(ad + 8'(j))}, {24'h0, rd[8 * (j % 4) +: 8]});
    end
  endtask
  task automatic devst(input logic [15:0] e);
    xfer(2'h1, 1'b1, SLV, 8'h36, 5'h2, 32'h0, st);
    bus(0, 8'h10, 32'h0, rd);
    chk("device status", {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #9000000;
    num_errors++;
    $display("watchdog expired");
    test_done;
  end
  initial begin
    rd = $urandom(34335);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h00, 32'h0, rd);
    chk("ctrl reset", 32'h00020000, rd);
    bus(0, 8'h0c, 32'h0, rd);
    chk("status reset", 32'h0, rd);
    bus(1, 8'h24, 32'h5a5a5a5a, rd);
    bus(0, 8'h24, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
    // Random reads, read-last repeats and writes to protected places
    for (int i = 0; i < 8; i++) begin
      p = 1'($urandom);
      n = 5'(2 + 2 * ($urandom % 8));
      a = 8'(2 * ($urandom % 17));
      wd = $urandom;
      if (i == 0) begin
        n = 5'h6;
        a = 8'h2e;
      end
      xfer(2'h1, p, SLV, a, n, 32'h0, st);
      chk("read status", 32'h2, st);
      rdchk(a, n);
      xfer(2'h2, p, SLV, 8'h0, n, 32'h0, st);
      chk("last status", 32'h2, st);
      rdchk(a, n);
      xfer(2'h0, p, SLV, a & 8'h1c, 5'(2 + 2 * (i % 2)), wd, st);
      chk("write status", 32'h2, st);
    end
    $display("random test done");
    fault <= 2'h3;
    @(posedge hclk);
    fault <= 2'h0;
    devst(16'h0003);
    xfer(2'h0, 1'b1, SLV, 8'h36, 5'h2, 32'h0001, st);
    devst(16'h0002);
    xfer(2'h0, 1'b0, SLV, 8'h22, 5'h2, 32'hb169, st);
    devst(16'h0000);
    $display("status test done");
    xfer(2'h0, 1'b0, SLV, 8'h22, 5'h2, 32'h6c32, st);
    xfer(2'h1, 1'b0, SLV, 8'h00, 5'h2, 32'h0, st);
    chk("asleep", 32'h6, st);
    xfer(2'h0, 1'b0, SLV, 8'h22, 5'h2, 32'h6c32, st);
    xfer(2'h3, 1'b0, SLV, 8'h00, 5'h2, 32'h0, st);
    xfer(2'h1, 1'b0, SLV, 8'h00, 5'h2, 32'h0, st);
    chk("awake", 32'h2, st);
    $display("sleep test done");
    bad_crc <= 1'b1;
    xfer(2'h1, 1'b1, SLV, 8'h04, 5'h4, 32'h0, st);
    chk("bad check", 32'ha, st);
    bad_crc <= 1'b0;
    xfer(2'h1, 1'b0, SLV ^ 7'h40, 8'h00, 5'h2, 32'h0, st);
    chk("wrong address", 32'h6, st);
    $display("fault test done");
    test_done;
  end
endmodule
bind spc_i2c_host spc_chk #(.QUARTER(QUARTER)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire
